/* File: hw/power_manager_defs.vh */
`ifndef POWER_MANAGER_DEFS_VH
`define POWER_MANAGER_DEFS_VH

// Floppy host register offsets (3-bit address within the unit)
`define OFS_STATUS_A 3'h0
`define OFS_STATUS_B 3'h1
`define OFS_DRIVE_OUT 3'h2
`define OFS_RATE_MAIN 3'h4
`define OFS_CMD_DATA 3'h5
`define OFS_DIN_CCR 3'h7

// Auto powerdown configuration bit positions
`define APD_FLOPPY_BIT 0
`define APD_PARALLEL_BIT 3
`define APD_SERIAL1_BIT 4
`define APD_SERIAL2_BIT 5

// PLL configuration: power-down control bit
`define PLL_OFF_BIT 1
// Direct power configuration: wake power bit
`define WAKE_POWER_BIT 7

// Drive output control: motor enable field
`define MOTOR_LSB 4
`define MOTOR_MSB 7

// Idle main status value
`define MSR_IDLE 8'h80

// Reset values
`define DOR_RESET 8'h00
`define RATE_RESET 8'h02
`define CCR_RESET 8'h02
`define CFG_RESET 8'h00

// Floppy auto powerdown timer
`define APD_TIME_MS 10
`define CLK_HZ 40000000

// Extended control mode codes
`define ECR_SPP 3'h0
`define ECR_BIDIR 3'h1
`define ECR_EPP 3'h4

`endif

/* File: hw/peripheral_power_manager.v */
// Overview of operation
// [R1] Host reads and writes are ignored, not decoded, while power-good is low.
// [R2] Wake inputs and wake output keep working on the standby supply.
// [R3] Standby power-on reset initialises wake configuration and wake logic.
// [R4] PLL off when control bit set; on only with wake bit 0, power-good 1.
// [R5] Status, drive, rate and config register access keeps the unit asleep.
// [R6] Main status read or data register access wakes the floppy unit.
// [R7] Reads in powerdown show true status; writes held and shown later.
// [R8] After a non-waking access the unit stays in low power.
// [R9] Host bus inputs remain live in powerdown so accesses can wake.
// [R10] Motor, select, write data, write gate tristate; seek, head, density driven.
// [R11] Local control and programming pins work regardless of powerdown.
// [R12] Config bits 4 and 5 enable serial auto powerdown, one per port.
// [R13] Transmitter sleeps once holding buffer and shift register are empty.
// [R14] Receiver sleeps when its FIFO is empty and it awaits a start bit.
// [R15] Ring-indicate interrupt keeps tracking its input while port sleeps.
// [R16] Transmit holding write wakes transmitter; receive line change wakes receiver.
// [R17] Config bit 3 enables parallel port auto powerdown of unused logic.
// [R18] EPP logic sleeps when EPP not enabled or ECP mode not selecting EPP.
// [R19] ECP logic sleeps when ECP not enabled or mode is SPP, bidir or EPP.
// [R20] Parallel powerdown re-evaluated whenever extended or configured mode changes.
// [R21] Floppy sleeps: bit 0 set, motors off, idle 80H, head unloaded, 10 ms.
// [R22] Setting a motor enable bit wakes the floppy; reading it does not.
// [R23] Each unit exports a powered-down flag that gates its clock off.
`timescale 1ns/1ps
`include "power_manager_defs.vh"

module peripheral_power_manager #(
    parameter APD_CYCLES = (`APD_TIME_MS * (`CLK_HZ / 1000)),
    parameter NUM_UART = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire standby_por_i,
    input wire power_good_internal_i,
    input wire [2:0] host_addr_i,
    input wire host_rd_i,
    input wire host_wr_i,
    input wire [7:0] host_wdata_i,
    input wire [7:0] status_a_i,
    input wire [7:0] status_b_i,
    input wire [7:0] drive_input_i,
    input wire [7:0] main_status_i,
    input wire [7:0] fifo_rdata_i,
    input wire fdc_int_i,
    input wire head_unloaded_i,
    input wire [7:0] direct_power_config_i,
    input wire [7:0] auto_powerdown_config_i,
    input wire [7:0] pll_config_reg_i,
    input wire [NUM_UART-1:0] thr_empty_i,
    input wire [NUM_UART-1:0] tsr_empty_i,
    input wire [NUM_UART-1:0] transmit_holding_wr_i,
    input wire [NUM_UART-1:0] rx_fifo_empty_i,
    input wire [NUM_UART-1:0] rx_idle_i,
    input wire [NUM_UART-1:0] serial_receive_line_i,
    input wire [NUM_UART-1:0] ring_indicate_n_i,
    input wire epp_enabled_i,
    input wire ecp_enabled_i,
    input wire [2:0] ecr_mode_i,
    input wire [7:0] wake_enable_i,
    input wire wake_cfg_wr_i,
    input wire keyboard_clock_pin_i,
    input wire mouse_clock_pin_i,
    input wire infrared_receive_i,
    input wire motor_on_zero_n_i,
    input wire drive_select_zero_n_i,
    input wire write_data_out_n_i,
    input wire write_gate_out_n_i,
    input wire step_way_select_n_i,
    input wire head_seek_pulse_n_i,
    input wire head_side_select_n_i,
    input wire [1:0] density_select_i,
    output reg [7:0] host_rdata_o,
    output reg host_rdata_valid_o,
    output reg [7:0] drive_output_control_o,
    output reg [7:0] rate_select_reg_o,
    output reg [7:0] rate_config_control_o,
    output reg fifo_rd_o,
    output reg fifo_wr_o,
    output reg [7:0] fifo_wdata_o,
    output reg fdc_powered_down_o,
    output reg fdc_clk_en_o,
    output reg [NUM_UART-1:0] tx_powered_down_o,
    output reg [NUM_UART-1:0] rx_powered_down_o,
    output reg [NUM_UART-1:0] uart_clk_en_o,
    output reg [NUM_UART-1:0] ring_change_irq_o,
    output reg epp_powered_down_o,
    output reg ecp_powered_down_o,
    output reg [1:0] par_clk_en_o,
    output reg pll_power_down_o,
    output reg pll_select_o,
    output reg wake_event_n_o,
    output reg motor_on_zero_n_o,
    output reg motor_on_zero_oe_n_o,
    output reg drive_select_zero_n_o,
    output reg drive_select_zero_oe_n_o,
    output reg write_data_out_n_o,
    output reg write_data_out_oe_n_o,
    output reg write_gate_out_n_o,
    output reg write_gate_out_oe_n_o,
    output reg step_way_select_n_o,
    output reg head_seek_pulse_n_o,
    output reg head_side_select_n_o,
    output reg [1:0] density_select_o
);

    ////////////////////////////////////////////////////////////////////////
    // Host access qualification
    ////////////////////////////////////////////////////////////////////////

    // Decode only while main power is good
    wire rd_ok = host_rd_i & power_good_internal_i; // see [R1]
    wire wr_ok = host_wr_i & power_good_internal_i; // see [R1]

    // Waking accesses
    wire wake_msr = rd_ok & (host_addr_i == `OFS_RATE_MAIN); // see [R6]
    wire wake_data = (rd_ok | wr_ok) & (host_addr_i == `OFS_CMD_DATA); // see [R6]
    wire wake_motor = wr_ok & (host_addr_i == `OFS_DRIVE_OUT)
        & (|host_wdata_i[`MOTOR_MSB:`MOTOR_LSB]); // see [R22]
    wire fdc_wake = wake_msr | wake_data | wake_motor;

    ////////////////////////////////////////////////////////////////////////
    // Floppy host registers, held through powerdown
    ////////////////////////////////////////////////////////////////////////

    // Writes latch asleep or awake
    always @(posedge clk_i) begin // see [R9]
        if (rst_i) begin
            drive_output_control_o <= `DOR_RESET;
            rate_select_reg_o <= `RATE_RESET;
            rate_config_control_o <= `CCR_RESET;
        end else if (wr_ok) begin
            case (host_addr_i)
                `OFS_DRIVE_OUT: drive_output_control_o <= host_wdata_i; // see [R7]
                `OFS_RATE_MAIN: rate_select_reg_o <= host_wdata_i; // see [R5]
                `OFS_DIN_CCR: rate_config_control_o <= host_wdata_i; // see [R5]
                default: ;
            endcase
        end
    end

    // Read mux, true status
    reg [7:0] next_rdata;
    always @* begin
        case (host_addr_i)
            `OFS_STATUS_A: next_rdata = status_a_i; // see [R5]
            `OFS_STATUS_B: next_rdata = status_b_i; // see [R5]
            `OFS_DRIVE_OUT: next_rdata = drive_output_control_o; // see [R7]
            `OFS_RATE_MAIN: next_rdata = main_status_i;
            `OFS_CMD_DATA: next_rdata = fifo_rdata_i;
            `OFS_DIN_CCR: next_rdata = drive_input_i; // see [R5]
            default: next_rdata = 8'h00;
        endcase
    end

    // Read answer and data strobes
    always @(posedge clk_i) begin
        if (rst_i) begin
            host_rdata_o <= 8'h00;
            host_rdata_valid_o <= 1'b0;
            fifo_rd_o <= 1'b0;
            fifo_wr_o <= 1'b0;
            fifo_wdata_o <= 8'h00;
        end else begin
            host_rdata_valid_o <= rd_ok;
            host_rdata_o <= rd_ok ? next_rdata : 8'h00;
            fifo_rd_o <= rd_ok & (host_addr_i == `OFS_CMD_DATA);
            fifo_wr_o <= wr_ok & (host_addr_i == `OFS_CMD_DATA);
            if (wr_ok & (host_addr_i == `OFS_CMD_DATA)) begin
                fifo_wdata_o <= host_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Floppy auto powerdown
    ////////////////////////////////////////////////////////////////////////

    reg [31:0] apd_count;
    wire fdc_apd_en = auto_powerdown_config_i[`APD_FLOPPY_BIT]; // see [R21]
    wire motors_off = ~|drive_output_control_o[`MOTOR_MSB:`MOTOR_LSB];
    wire fdc_idle = (main_status_i == `MSR_IDLE) & ~fdc_int_i;
    wire timer_done = (apd_count >= APD_CYCLES);
    wire fdc_sleep_ok = fdc_apd_en & motors_off & fdc_idle
        & head_unloaded_i & timer_done; // see [R21]

    // Timer restarts on wake, cleared when off
    always @(posedge clk_i) begin
        if (rst_i || !fdc_apd_en || fdc_wake) begin // see [R21]
            apd_count <= 32'h00000000;
        end else if (!timer_done) begin
            apd_count <= apd_count + 32'h00000001;
        end
    end

    // Waking accesses clear sleep; so does losing any sleep condition
    always @(posedge clk_i) begin
        if (rst_i) begin
            fdc_powered_down_o <= 1'b0;
            fdc_clk_en_o <= 1'b1;
        end else if (fdc_wake) begin // see [R6]
            fdc_powered_down_o <= 1'b0;
            fdc_clk_en_o <= 1'b1;
        end else begin
            fdc_powered_down_o <= fdc_sleep_ok; // see [R8]
            fdc_clk_en_o <= ~fdc_sleep_ok; // see [R23]
        end
    end

    // Drive pins, some tristated asleep
    always @(posedge clk_i) begin // see [R10]
        if (rst_i) begin
            motor_on_zero_oe_n_o <= 1'b0;
            drive_select_zero_oe_n_o <= 1'b0;
            write_data_out_oe_n_o <= 1'b0;
            write_gate_out_oe_n_o <= 1'b0;
            motor_on_zero_n_o <= 1'b1;
            drive_select_zero_n_o <= 1'b1;
            write_data_out_n_o <= 1'b1;
            write_gate_out_n_o <= 1'b1;
            step_way_select_n_o <= 1'b1;
            head_seek_pulse_n_o <= 1'b1;
            head_side_select_n_o <= 1'b1;
            density_select_o <= 2'b00;
        end else begin
            motor_on_zero_oe_n_o <= fdc_powered_down_o; // see [R10]
            drive_select_zero_oe_n_o <= fdc_powered_down_o;
            write_data_out_oe_n_o <= fdc_powered_down_o;
            write_gate_out_oe_n_o <= fdc_powered_down_o;
            motor_on_zero_n_o <= motor_on_zero_n_i;
            drive_select_zero_n_o <= drive_select_zero_n_i;
            write_data_out_n_o <= write_data_out_n_i;
            write_gate_out_n_o <= write_gate_out_n_i;
            step_way_select_n_o <= step_way_select_n_i; // see [R11]
            head_seek_pulse_n_o <= head_seek_pulse_n_i;
            head_side_select_n_o <= head_side_select_n_i;
            density_select_o <= density_select_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial port auto powerdown, one slice per port
    ////////////////////////////////////////////////////////////////////////

    genvar u;
    generate
        for (u = 0; u < NUM_UART; u = u + 1) begin : g_uart
            wire apd_en = auto_powerdown_config_i[`APD_SERIAL1_BIT + u]; // see [R12]
            reg rx_last;
            reg ri_last;
            wire rx_edge = rx_last ^ serial_receive_line_i[u];
            // Transmitter sleep and wake
            always @(posedge clk_i) begin
                if (rst_i || !apd_en) begin
                    tx_powered_down_o[u] <= 1'b0;
                end else if (transmit_holding_wr_i[u]) begin // see [R16]
                    tx_powered_down_o[u] <= 1'b0;
                end else if (thr_empty_i[u] & tsr_empty_i[u]) begin // see [R13]
                    tx_powered_down_o[u] <= 1'b1;
                end
            end
            // Receiver sleep; line edge wins
            always @(posedge clk_i) begin
                if (rst_i) begin
                    rx_last <= 1'b1;
                end else begin
                    rx_last <= serial_receive_line_i[u];
                end
                if (rst_i || !apd_en) begin
                    rx_powered_down_o[u] <= 1'b0;
                end else if (rx_edge) begin // see [R16]
                    rx_powered_down_o[u] <= 1'b0;
                end else if (rx_fifo_empty_i[u] & rx_idle_i[u]) begin // see [R14]
                    rx_powered_down_o[u] <= 1'b1;
                end
            end
            // Clock gate and ring change
            always @(posedge clk_i) begin
                if (rst_i) begin
                    ri_last <= 1'b1;
                    ring_change_irq_o[u] <= 1'b0;
                    uart_clk_en_o[u] <= 1'b1;
                end else begin
                    ri_last <= ring_indicate_n_i[u];
                    ring_change_irq_o[u] <= ri_last ^ ring_indicate_n_i[u]; // see [R15]
                    uart_clk_en_o[u] <= ~(tx_powered_down_o[u]
                        & rx_powered_down_o[u]); // see [R23]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Parallel port auto powerdown
    ////////////////////////////////////////////////////////////////////////

    wire par_apd_en = auto_powerdown_config_i[`APD_PARALLEL_BIT]; // see [R17]
    wire epp_off = ~epp_enabled_i
        | (ecp_enabled_i & (ecr_mode_i != `ECR_EPP)); // see [R18]
    wire ecp_off = ~ecp_enabled_i | (ecr_mode_i == `ECR_SPP)
        | (ecr_mode_i == `ECR_BIDIR) | (ecr_mode_i == `ECR_EPP); // see [R19]

    // Re-evaluated every cycle
    always @(posedge clk_i) begin // see [R20]
        if (rst_i) begin
            epp_powered_down_o <= 1'b0;
            ecp_powered_down_o <= 1'b0;
            par_clk_en_o <= 2'b11;
        end else begin
            epp_powered_down_o <= par_apd_en & epp_off;
            ecp_powered_down_o <= par_apd_en & ecp_off;
            par_clk_en_o <= {~(par_apd_en & ecp_off),
                ~(par_apd_en & epp_off)}; // see [R23]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL power and select
    ////////////////////////////////////////////////////////////////////////

    // Reserved cases: powered, not selected
    always @(posedge clk_i) begin
        if (rst_i) begin
            pll_power_down_o <= 1'b0;
            pll_select_o <= 1'b0;
        end else begin
            pll_power_down_o <= pll_config_reg_i[`PLL_OFF_BIT]; // see [R4]
            pll_select_o <= ~pll_config_reg_i[`PLL_OFF_BIT]
                & ~direct_power_config_i[`WAKE_POWER_BIT]
                & power_good_internal_i; // see [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-event logic on standby reset only
    ////////////////////////////////////////////////////////////////////////

    reg [7:0] wake_enable;
    reg [4:0] wake_last;
    wire [4:0] wake_src = {ring_indicate_n_i[0], ring_indicate_n_i[1],
        serial_receive_line_i[1], infrared_receive_i, keyboard_clock_pin_i};

    // Standby domain: main reset ignored
    always @(posedge clk_i) begin // see [R2]
        if (standby_por_i) begin // see [R3]
            wake_enable <= `CFG_RESET;
            wake_last <= 5'h1F;
            wake_event_n_o <= 1'b1;
        end else begin
            if (wake_cfg_wr_i) begin
                wake_enable <= wake_enable_i;
            end
            wake_last <= wake_src;
            if (|((wake_last ^ wake_src) & wake_enable[4:0])
                | (wake_enable[5] & ~mouse_clock_pin_i)) begin
                wake_event_n_o <= 1'b0;
            end else if (wake_cfg_wr_i) begin
                wake_event_n_o <= 1'b1;
            end
        end
    end

endmodule // peripheral_power_manager

/* File: verif/power_manager_asserts.sv */
`timescale 1ns/1ps
module power_manager_asserts #(
    parameter NUM_UART = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire power_good_internal_i,
    input wire [2:0] host_addr_i,
    input wire host_rd_i,
    input wire host_wr_i,
    input wire [7:0] auto_powerdown_config_i,
    input wire [7:0] pll_config_reg_i,
    input wire [NUM_UART-1:0] thr_empty_i,
    input wire [NUM_UART-1:0] tsr_empty_i,
    input wire [NUM_UART-1:0] transmit_holding_wr_i,
    input wire [NUM_UART-1:0] ring_indicate_n_i,
    input wire ecp_enabled_i,
    input wire [2:0] ecr_mode_i,
    input wire host_rdata_valid_o,
    input wire fdc_powered_down_o,
    input wire fdc_clk_en_o,
    input wire [NUM_UART-1:0] tx_powered_down_o,
    input wire [NUM_UART-1:0] ring_change_irq_o,
    input wire ecp_powered_down_o,
    input wire pll_power_down_o,
    input wire pll_select_o,
    input wire motor_on_zero_oe_n_o,
    input wire write_gate_out_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Any host strobe and the waking accesses
    wire acc = host_rd_i | host_wr_i;
    wire pg = power_good_internal_i;
    wire wake_acc = host_rd_i && host_addr_i == 3'h4 || host_addr_i == 3'h5;

    ////////////////////////////////////////////////////////////////////////
    refuse_a: assert property (
        !pg && acc |=> !host_rdata_valid_o)
        else $error("Access answered");
    msr_wake_a: assert property (
        pg && acc && wake_acc |=> !fdc_powered_down_o)
        else $error("Floppy not woken");
    stay_down_a: assert property (
        pg && host_rd_i && host_addr_i == 3'h0 && fdc_powered_down_o
        && auto_powerdown_config_i[0] |=> fdc_powered_down_o)
        else $error("Status read woke");
    pin_tri_a: assert property (
        1'b1 |=> motor_on_zero_oe_n_o == $past(fdc_powered_down_o)
        && write_gate_out_oe_n_o == $past(fdc_powered_down_o))
        else $error("Drive enable wrong");
    clk_gate_a: assert property (
        fdc_clk_en_o != fdc_powered_down_o)
        else $error("Clock enable wrong");
    tx_sleep_a: assert property (
        auto_powerdown_config_i[4] && thr_empty_i[0] && tsr_empty_i[0]
        && !transmit_holding_wr_i[0] |=> tx_powered_down_o[0])
        else $error("No tx sleep");
    tx_wake_a: assert property (
        transmit_holding_wr_i[0] |=> !tx_powered_down_o[0])
        else $error("No tx wake");
    ring_irq_a: assert property (
        $changed(ring_indicate_n_i[0]) |=> ring_change_irq_o[0])
        else $error("No ring pulse");
    pll_off_a: assert property (
        pll_config_reg_i[1] |=> pll_power_down_o && !pll_select_o)
        else $error("PLL not off");
    ecp_down_a: assert property (
        auto_powerdown_config_i[3] && (!ecp_enabled_i || ecr_mode_i == 3'h0
        || ecr_mode_i == 3'h1 || ecr_mode_i == 3'h4) |=> ecp_powered_down_o)
        else $error("ECP not off");

    // Main scenarios reached
    cover property ($rose(fdc_powered_down_o));
    cover property ($rose(tx_powered_down_o[0]));
    cover property (ring_change_irq_o[0]);
endmodule // power_manager_asserts

bind peripheral_power_manager power_manager_asserts #(
    .NUM_UART(NUM_UART)) i_chk (.*);

/* File: verif/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
    input wire clk_i,
    output reg [2:0] host_addr_o,
    output reg host_rd_o,
    output reg host_wr_o,
    output reg [7:0] host_wdata_o
);
    // Idle bus at time zero
    initial {host_addr_o, host_rd_o, host_wr_o, host_wdata_o} = '0;

    // One-cycle write; inverted release data
    task automatic wr(input [2:0] a, input [7:0] d);
        @(posedge clk_i);
        host_addr_o <= a;
        host_wdata_o <= d;
        host_wr_o <= 1'b1;
        @(posedge clk_i);
        host_wr_o <= 1'b0;
        host_wdata_o <= ~d;
        host_addr_o <= ~a;
    endtask

    // One-cycle read; caller takes answer
    task automatic rd(input [2:0] a);
        @(posedge clk_i);
        host_addr_o <= a;
        host_rd_o <= 1'b1;
        @(posedge clk_i);
        host_rd_o <= 1'b0;
        host_addr_o <= ~a;
    endtask
endmodule // host_bus_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int APD = 20;
    reg clk_i, rst_i = '1, standby_por_i = '1, power_good_internal_i = '0;
    reg [7:0] status_a_i = '0, status_b_i = '0, drive_input_i = '0;
    reg [7:0] main_status_i = '0, fifo_rdata_i = '0, wake_enable_i = '0;
    reg [7:0] direct_power_config_i = '0, auto_powerdown_config_i = '0;
    reg [7:0] pll_config_reg_i = '0;
    reg fdc_int_i = '0, head_unloaded_i = '0, epp_enabled_i = '0;
    reg ecp_enabled_i = '0, wake_cfg_wr_i = '0, keyboard_clock_pin_i = '0;
    reg mouse_clock_pin_i = '0, infrared_receive_i = '0;
    reg [1:0] thr_empty_i = '0, tsr_empty_i = '0, transmit_holding_wr_i = '0;
    reg [1:0] rx_fifo_empty_i = '0, rx_idle_i = '0, serial_receive_line_i = '0;
    reg [1:0] ring_indicate_n_i = '1, density_select_i = '0;
    reg [2:0] ecr_mode_i = '0;
    reg motor_on_zero_n_i = '1, drive_select_zero_n_i = '1;
    reg write_data_out_n_i = '1, write_gate_out_n_i = '1;
    reg step_way_select_n_i = '1, head_seek_pulse_n_i = '1;
    reg head_side_select_n_i = '1;
    wire [2:0] host_addr_i;
    wire host_rd_i, host_wr_i, host_rdata_valid_o, fifo_rd_o, fifo_wr_o;
    wire [7:0] host_wdata_i, host_rdata_o, drive_output_control_o;
    wire [7:0] rate_select_reg_o, rate_config_control_o, fifo_wdata_o;
    wire fdc_powered_down_o, fdc_clk_en_o, epp_powered_down_o;
    wire ecp_powered_down_o, pll_power_down_o, pll_select_o, wake_event_n_o;
    wire [1:0] tx_powered_down_o, rx_powered_down_o, uart_clk_en_o;
    wire [1:0] ring_change_irq_o, par_clk_en_o, density_select_o;
    wire motor_on_zero_n_o, motor_on_zero_oe_n_o, drive_select_zero_n_o;
    wire drive_select_zero_oe_n_o, write_data_out_n_o, write_data_out_oe_n_o;
    wire write_gate_out_n_o, write_gate_out_oe_n_o, step_way_select_n_o;
    wire head_seek_pulse_n_o, head_side_select_n_o;
    wire [3:0] oe_n = {motor_on_zero_oe_n_o, drive_select_zero_oe_n_o,
        write_data_out_oe_n_o, write_gate_out_oe_n_o};
    int err_total = 0;
    int total_checks = 0;

    peripheral_power_manager #(.APD_CYCLES(APD), .NUM_UART(2)) i_dut (.*);
    host_bus_model u_host (.clk_i(clk_i), .host_addr_o(host_addr_i),
        .host_rd_o(host_rd_i), .host_wr_o(host_wr_i),
        .host_wdata_o(host_wdata_i));

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        err_total++;
        stop_test;
    end

    task automatic chk(input [15:0] seen, input [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic nxt;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wait_fdc(input bit lvl);
        for (int n = 0; n < 60 && fdc_powered_down_o !== lvl; n++)
            nxt;
        chk(fdc_powered_down_o, lvl);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_refuse;
        @(posedge clk_i) power_good_internal_i <= 1'b0;
        u_host.wr(3'h2, 8'h30);
        u_host.rd(3'h0);
        #1 chk(host_rdata_valid_o, 0);
        chk(drive_output_control_o, 8'h00);
        @(posedge clk_i) power_good_internal_i <= 1'b1;
        u_host.rd(3'h6);
        #1 chk({host_rdata_valid_o, host_rdata_o}, 9'h100);
        $display("refuse done");
    endtask

    task automatic test_floppy;
        @(posedge clk_i);
        main_status_i <= 8'h80;
        head_unloaded_i <= 1'b1;
        status_a_i <= 8'hA5;
        auto_powerdown_config_i <= 8'h01;
        repeat (APD - 4) @(posedge clk_i);
        #1 chk(fdc_powered_down_o, 0);
        wait_fdc(1);
        @(posedge clk_i);
        step_way_select_n_i <= 1'b0;
        density_select_i <= 2'h2;
        nxt;
        chk({step_way_select_n_o, density_select_o}, 3'h2);
        chk(oe_n, 4'hF);
        u_host.rd(3'h0);
        #1 chk(host_rdata_o, 8'hA5);
        u_host.wr(3'h4, 8'h05);
        u_host.wr(3'h7, 8'h01);
        #1 chk(rate_select_reg_o, 8'h05);
        chk(rate_config_control_o, 8'h01);
        chk(fdc_powered_down_o, 1);
        u_host.rd(3'h4);
        #1 chk({fdc_powered_down_o, host_rdata_o}, 9'h080);
        wait_fdc(1);
        u_host.wr(3'h5, 8'h3C);
        #1 chk({fdc_powered_down_o, fifo_wr_o, fifo_wdata_o},
            10'h13C);
        wait_fdc(1);
        u_host.rd(3'h5);
        #1 chk({fdc_powered_down_o, fifo_rd_o}, 2'h1);
        wait_fdc(1);
        u_host.wr(3'h2, 8'h10);
        #1 chk({fdc_powered_down_o, drive_output_control_o},
            9'h010);
        nxt;
        chk(oe_n, 4'h0);
        u_host.wr(3'h2, 8'h00);
        @(posedge clk_i) auto_powerdown_config_i <= 8'h00;
        $display("floppy done");
    endtask

    task automatic test_serial;
        logic [1:0] seen;
        @(posedge clk_i);
        auto_powerdown_config_i <= 8'h30;
        {thr_empty_i, tsr_empty_i, rx_fifo_empty_i, rx_idle_i} <= 8'hFF;
        nxt;
        chk(tx_powered_down_o, 2'h3);
        chk(rx_powered_down_o, 2'h3);
        @(posedge clk_i);
        transmit_holding_wr_i <= 2'h1;
        serial_receive_line_i <= 2'h2;
        ring_indicate_n_i <= 2'h2;
        nxt;
        transmit_holding_wr_i <= 2'h0;
        chk({tx_powered_down_o, rx_powered_down_o}, 4'h9);
        chk(uart_clk_en_o, 2'h0);
        seen = ring_change_irq_o;
        repeat (2) begin
            nxt;
            seen |= ring_change_irq_o;
        end
        chk(seen, 2'h1);
        @(posedge clk_i) auto_powerdown_config_i <= 8'h10;
        nxt;
        chk(tx_powered_down_o, 2'h1);
        @(posedge clk_i) auto_powerdown_config_i <= 8'h00;
        $display("serial done");
    endtask

    task automatic test_parallel;
        logic [55:0] t = {8'h60, 8'hCE, 8'h93, 8'hE7, 8'hE3, 8'hED, 8'hF2};
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_i);
            {auto_powerdown_config_i[3], epp_enabled_i, ecp_enabled_i,
                ecr_mode_i} <= t[8*i+2 +: 6];
            nxt;
            chk({ecp_powered_down_o, epp_powered_down_o},
                t[8*i +: 2]);
            chk(par_clk_en_o ^ t[8*i +: 2], 2'h3);
        end
        $display("parallel done");
    endtask

    task automatic test_pll;
        logic [24:0] t = {5'h05, 5'h16, 5'h0C, 5'h1A, 5'h00};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_i);
            {pll_config_reg_i[1], direct_power_config_i[7],
                power_good_internal_i} <= t[5*i+2 +: 3];
            nxt;
            chk({pll_power_down_o, pll_select_o}, t[5*i +: 2]);
        end
        $display("pll done");
    endtask

    task automatic test_wake;
        @(posedge clk_i);
        power_good_internal_i <= 1'b0;
        wake_enable_i <= 8'h01;
        wake_cfg_wr_i <= 1'b1;
        @(posedge clk_i) wake_cfg_wr_i <= 1'b0;
        nxt;
        chk(wake_event_n_o, 1);
        @(posedge clk_i) keyboard_clock_pin_i <= 1'b1;
        repeat (2) nxt;
        chk(wake_event_n_o, 0);
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        nxt;
        chk(wake_event_n_o, 0);
        @(posedge clk_i) standby_por_i <= 1'b1;
        @(posedge clk_i) standby_por_i <= 1'b0;
        @(posedge clk_i) keyboard_clock_pin_i <= 1'b0;
        repeat (2) nxt;
        chk(wake_event_n_o, 1);
        @(posedge clk_i) power_good_internal_i <= 1'b1;
        $display("wake done");
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        {rst_i, standby_por_i, power_good_internal_i} <= 3'h1;
        test_refuse;
        test_floppy;
        test_serial;
        test_parallel;
        test_pll;
        test_wake;
        stop_test;
    end
endmodule // tb_top
